/* File: rtl/far_consts.vh */
`ifndef FAR_CONSTS_VH
`define FAR_CONSTS_VH
// Register byte offsets
`define FAR_CTRL_OFS     8'h00
`define FAR_SER_OFS      8'h04
`define FAR_DLY_OFS      8'h08
`define FAR_STAT_OFS     8'h20
// Control register fields
`define FAR_ATT_LSB      0
`define FAR_ATT_MSB      3
`define FAR_SRC_LSB      4
`define FAR_SRC_MSB      5
`define FAR_ACT_LSB      8
`define FAR_ACT_MSB      10
// Serial setup fields
`define FAR_ADR_LSB      0
`define FAR_ADR_MSB      7
`define FAR_BAUD_LSB     8
`define FAR_BAUD_MSB     10
`define FAR_PAR_BIT      12
// Reset values
`define FAR_ATT_RST      4'h0
`define FAR_SRC_RST      2'h1
`define FAR_ACT_RST      3'h3
`define FAR_ADR_RST      8'h01
`define FAR_BAUD_RST     3'h2
`define FAR_PAR_RST      1'h0
`define FAR_DLY_RST      12'h000
// Limits and encodings
`define FAR_ATT_MAX      4'ha
`define FAR_ADR_MIN      8'h01
`define FAR_ADR_MAX      8'hf7
`define FAR_BAUD_MAX     3'h4
`define FAR_DLY_MAX      12'he10
`define FAR_SRC_PANEL    2'h1
`define FAR_SRC_REMOTE   2'h2
`define FAR_SRC_SERIAL   2'h3
`define FAR_ACT_OFF      3'h0
`define FAR_ACT_WARN     3'h1
`define FAR_ACT_COAST    3'h2
`define FAR_ACT_STOP     3'h3
`define FAR_ACT_BRAKE    3'h4
// Alarm indices
`define FAR_PHASE        0
`define FAR_HEAT         1
`define FAR_UNBAL        2
`define FAR_OVER         3
`define FAR_UNDER        4
`define FAR_LINK         5
// Timing
`define FAR_CLK_HZ       25000000
`define FAR_TICK_S       1
`define FAR_QUIET_MIN    10
`endif

/* File: rtl/far_ctrl.v */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "far_consts.vh"

module far_ctrl #(
  parameter TICK_CYC = `FAR_CLK_HZ * `FAR_TICK_S,
  parameter QUIET_S  = `FAR_QUIET_MIN * 60
) (
  input  wire        pclk,          // System clock
  input  wire        presetn,       // Async reset, active low
  input  wire        psel,          // APB select
  input  wire        penable,       // APB access phase
  input  wire        pwrite,        // APB write
  input  wire [7:0]  paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  output reg  [31:0] prdata,        // APB read data
  output reg         pready,        // APB ready
  output reg         pslverr,       // APB error
  input  wire        cfg_panel,     // Bus master is the front panel
  input  wire [4:0]  fault_pin,     // Raw fault levels, alarms 0..4
  input  wire        mains_ok_pin,  // Mains present at input
  input  wire        link_ok_pin,   // Serial link alive
  input  wire        motor_run_pin, // Motor operating
  input  wire        action_done,   // Alarm action finished
  input  wire [5:0]  act_on,        // Alarm action is neither off nor warning
  input  wire        start_cmd,     // Start from selected source
  input  wire        stop_cmd,      // Stop from any source
  input  wire        panel_reset,   // Reset from front panel
  output reg  [5:0]  alarm_flags,   // Displayed alarms
  output reg         alarm_relay,   // Alarm relay energised
  output reg         coast_req,     // Motor voltage off
  output reg         stop_req,      // Normal stop ramp
  output reg         brake_req,     // Alarm brake
  output reg         restart_req,   // One-cycle restart pulse
  output reg         attempts_full  // Counter reached maximum
);

  // Restart timer states, one-hot
  localparam ST_IDLE  = 3'b001;
  localparam ST_ARM   = 3'b010;
  localparam ST_COUNT = 3'b100;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Idle-high pins read low for two edges after reset;
  // link and mains terms are gated, so no false alarm
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= {motor_run_pin, link_ok_pin, mains_ok_pin, fault_pin};
      sync2_ff <= sync1_ff;
    end
  end
  wire [4:0] fault_s = sync2_ff[4:0];
  wire       mains_s = sync2_ff[5];
  wire       link_s  = sync2_ff[6];
  wire       run_s   = sync2_ff[7];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg  [3:0]  att_ff;
  reg  [1:0]  src_ff;
  reg  [2:0]  act_ff;
  reg  [7:0]  adr_ff;
  reg  [2:0]  baud_ff;
  reg         par_ff;
  reg  [11:0] dly_ff [0:5];
  // Restarts since the last stop, less one per quiet spell
  reg  [3:0]  cnt_ff;
  reg  [2:0]  st_ff  [0:5];
  reg  [11:0] tmr_ff [0:5];

  wire       ar_on    = (att_ff != 4'h0);
  wire       acc_done = psel & penable & pready;
  wire       wr_en    = acc_done & pwrite;
  wire [5:0] link_on;
  assign link_on = {(act_ff >= `FAR_ACT_COAST), act_on[4:0]};

  // Delay register index, or 7 when not a delay register
  function [2:0] dly_idx;
    input [7:0] a;
    begin
      if (a >= `FAR_DLY_OFS && a < `FAR_STAT_OFS && a[1:0] == 2'b00)
        dly_idx = a[4:2] - 3'h2;
      else
        dly_idx = 3'h7;
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `FAR_CTRL_OFS) || (a == `FAR_SER_OFS) ||
               (a == `FAR_STAT_OFS) || (dly_idx(a) != 3'h7);
    end
  endfunction

  // Shared by read mux and write decode
  wire [2:0] wr_idx = dly_idx(paddr);

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  reg [31:0] nxt_rd;
  reg [5:0]  run_vec;
  integer    k;
  always @* begin
    nxt_rd = 32'h0000_0000;
    run_vec = 6'h00;
    for (k = 0; k < 6; k = k + 1)
      run_vec[k] = (st_ff[k] == ST_COUNT);
    if (paddr == `FAR_CTRL_OFS) begin
      nxt_rd[`FAR_ATT_MSB:`FAR_ATT_LSB] = att_ff;
      nxt_rd[`FAR_SRC_MSB:`FAR_SRC_LSB] = src_ff;
      nxt_rd[`FAR_ACT_MSB:`FAR_ACT_LSB] = act_ff;
    end else if (paddr == `FAR_SER_OFS) begin
      nxt_rd[`FAR_ADR_MSB:`FAR_ADR_LSB] = adr_ff;
      nxt_rd[`FAR_BAUD_MSB:`FAR_BAUD_LSB] = baud_ff;
      nxt_rd[`FAR_PAR_BIT] = par_ff;
    end else if (paddr == `FAR_STAT_OFS) begin
      nxt_rd[5:0] = alarm_flags;
      nxt_rd[13:8] = run_vec;
      nxt_rd[19:16] = cnt_ff;
    end else if (wr_idx != 3'h7 && ar_on) begin
      nxt_rd[11:0] = dly_ff[wr_idx];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      // Ready is held for one edge only, so back-to-back
      // transfers each get their own wait state
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      if (psel & penable & ~pready)
        prdata <= nxt_rd;
    end
  end

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  // Serial master cannot change its own link setup,
  // so a bad write cannot cut it off
  wire ser_ok = cfg_panel &
                (src_ff == `FAR_SRC_PANEL || src_ff == `FAR_SRC_REMOTE);
  wire [7:0] w_adr  = pwdata[`FAR_ADR_MSB:`FAR_ADR_LSB];
  wire [2:0] w_baud = pwdata[`FAR_BAUD_MSB:`FAR_BAUD_LSB];
  wire [3:0] w_att  = pwdata[`FAR_ATT_MSB:`FAR_ATT_LSB];
  wire [2:0] w_act  = pwdata[`FAR_ACT_MSB:`FAR_ACT_LSB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_ff  <= `FAR_ATT_RST;
      src_ff  <= `FAR_SRC_RST;
      act_ff  <= `FAR_ACT_RST;
      adr_ff  <= `FAR_ADR_RST;
      baud_ff <= `FAR_BAUD_RST;
      par_ff  <= `FAR_PAR_RST;
    end else if (wr_en) begin
      if (paddr == `FAR_CTRL_OFS) begin
        // Out-of-range fields keep the old value
        if (w_att <= `FAR_ATT_MAX)
          att_ff <= w_att;
        if (pwdata[`FAR_SRC_MSB:`FAR_SRC_LSB] != 2'h0)
          src_ff <= pwdata[`FAR_SRC_MSB:`FAR_SRC_LSB];
        if (w_act <= `FAR_ACT_BRAKE)
          act_ff <= w_act;
      end
      if (paddr == `FAR_SER_OFS && ser_ok) begin
        if (w_adr >= `FAR_ADR_MIN && w_adr <= `FAR_ADR_MAX)
          adr_ff <= w_adr;
        if (w_baud <= `FAR_BAUD_MAX)
          baud_ff <= w_baud;
        par_ff <= pwdata[`FAR_PAR_BIT];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_dly
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          dly_ff[g] <= `FAR_DLY_RST;
        // Out-of-range delays are dropped, not clipped
        else if (wr_en && ar_on && wr_idx == g && pwdata[11:0] <= `FAR_DLY_MAX)
          dly_ff[g] <= pwdata[11:0];
      end
    end
  endgenerate

  // ----------------------------------------
  // One-second tick and quiet timer
  // ----------------------------------------
  // Ticks are free-running, so a delay of N seconds
  // ends between N-1 and N seconds after it starts
  reg [24:0] pre_ff;
  reg        tick_ff;
  reg [9:0]  quiet_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff  <= 25'h0;
      tick_ff <= 1'b0;
    end else if (pre_ff == TICK_CYC - 1) begin
      pre_ff  <= 25'h0;
      tick_ff <= 1'b1;
    end else begin
      pre_ff  <= pre_ff + 25'h1;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alarm flags and link loss action
  // ----------------------------------------
  wire [5:0] expire;
  // Only a running motor can lose its link; a stopped
  // motor with a silent link raises nothing
  wire       link_brk = (src_ff == `FAR_SRC_SERIAL) & run_s & ~link_s &
                        (act_ff != `FAR_ACT_OFF);
  wire [5:0] set_vec  = {link_brk, fault_s};
  wire       link_clr = start_cmd |
                        ((act_ff == `FAR_ACT_WARN) & link_s);
  wire [5:0] clr_vec  = expire | {6{panel_reset}} |
                        {link_clr, 5'h00};
  wire       link_al  = alarm_flags[`FAR_LINK];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_flags <= 6'h00;
      alarm_relay <= 1'b0;
      coast_req   <= 1'b0;
      stop_req    <= 1'b0;
      brake_req   <= 1'b0;
    end else begin
      // A new fault wins over a clear in the same cycle
      alarm_flags <= (alarm_flags & ~clr_vec) | set_vec;
      // Relay and action lines lag the flags by one edge
      alarm_relay <= |alarm_flags;
      coast_req   <= link_al & (act_ff == `FAR_ACT_COAST);
      stop_req    <= link_al & (act_ff == `FAR_ACT_STOP);
      brake_req   <= link_al & (act_ff == `FAR_ACT_BRAKE);
    end
  end

  // ----------------------------------------
  // Restart delay timers
  // ----------------------------------------
  wire [5:0] go_vec;
  assign go_vec[`FAR_PHASE] = action_done;
  assign go_vec[`FAR_HEAT]  = ~fault_s[`FAR_HEAT];
  assign go_vec[`FAR_UNBAL] = ~fault_s[`FAR_UNBAL] | (~mains_s & action_done);
  assign go_vec[`FAR_OVER]  = ~fault_s[`FAR_OVER] | (~mains_s & action_done);
  assign go_vec[`FAR_UNDER] = ~fault_s[`FAR_UNDER] | (~mains_s & action_done);
  assign go_vec[`FAR_LINK]  = link_s;

  // Counter check here keeps a full counter in fault
  wire may_run = ar_on & (cnt_ff < att_ff) & ~stop_cmd;

  generate
    for (g = 0; g < 6; g = g + 1) begin : g_tmr
      reg exp_ff;
      assign expire[g] = exp_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_ff[g]  <= ST_IDLE;
          tmr_ff[g] <= 12'h000;
          exp_ff    <= 1'b0;
        end else begin
          exp_ff    <= 1'b0;
          if (!alarm_flags[g] || !may_run) begin
            st_ff[g] <= ST_IDLE;
          end else begin
            case (st_ff[g])
              ST_IDLE: begin
                if (link_on[g] && dly_ff[g] != 12'h000)
                  st_ff[g] <= ST_ARM;
              end
              ST_ARM: begin
                if (go_vec[g]) begin
                  // Delay is latched here; a new setting applies from the next delay start, which can fall within the same held alarm
                  tmr_ff[g] <= dly_ff[g];
                  st_ff[g]  <= ST_COUNT;
                end
              end
              ST_COUNT: begin
                if (tick_ff) begin
                  tmr_ff[g] <= tmr_ff[g] - 12'h001;
                  // Expiry on the tick that finds one second left
                  if (tmr_ff[g] == 12'h001) begin
                    exp_ff    <= 1'b1;
                    st_ff[g]  <= ST_IDLE;
                  end
                end
              end
              default: st_ff[g] <= ST_IDLE;
            endcase
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Restart counter and restart request
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff        <= 4'h0;
      quiet_ff      <= 10'h000;
      restart_req   <= 1'b0;
      attempts_full <= 1'b0;
    end else begin
      // Panel reset only clears flags; restart_req is driven by expiry alone
      restart_req <= |expire;
      attempts_full <= ar_on & (cnt_ff >= att_ff);
      // Quiet timer saturates until the counter has something to drop
      if (|alarm_flags)
        quiet_ff <= 10'h000;
      else if (tick_ff && quiet_ff != QUIET_S - 1)
        quiet_ff <= quiet_ff + 10'h001;
      // Stop has priority and also ends a pending decrement
      if (stop_cmd) begin
        cnt_ff <= 4'h0;
      end else if (|expire) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (tick_ff && quiet_ff == QUIET_S - 1 && cnt_ff != 4'h0) begin
        cnt_ff   <= cnt_ff - 4'h1;
        quiet_ff <= 10'h000;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/far_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module far_checker #(
  parameter TICK_CYC = 10,
  parameter QUIET_S  = 3
) (
  input wire logic       pclk,         // Clock
  input wire logic       presetn,      // Reset, low
  input wire logic       psel,         // Select
  input wire logic       penable,      // Access
  input wire logic [7:0] paddr,        // Address
  input wire logic       pready,       // Ready
  input wire logic       pslverr,      // Error
  input wire logic       stop_cmd,     // Stop
  input wire logic       panel_reset,  // Panel reset
  input wire logic [5:0] alarm_flags,  // Alarms
  input wire logic       alarm_relay,  // Relay
  input wire logic       coast_req,    // Coast
  input wire logic       stop_req,     // Stop ramp
  input wire logic       brake_req,    // Brake
  input wire logic       restart_req,  // Restart
  input wire logic       attempts_full // Counter full
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr) else $error("no error");
  a_relay_any: assert property (alarm_relay == |$past(alarm_flags)) else $error("relay");
  a_req_link: assert property ((coast_req || stop_req || brake_req) |-> $past(alarm_flags[5]))
    else $error("action without alarm");
  a_req_single: assert property ($onehot0({coast_req, stop_req, brake_req}))
    else $error("two actions");
  a_restart_pulse: assert property (restart_req |=> !restart_req) else $error("restart held");
  a_panel_nostart: assert property (panel_reset |=> !restart_req [*2])
    else $error("panel reset started motor");
  a_stop_clears: assert property (stop_cmd |-> ##[1:3] !attempts_full)
    else $error("counter kept");

  cover property ($rose(restart_req));
  cover property (brake_req);
  cover property (pslverr);
endmodule

bind far_ctrl far_checker #(.TICK_CYC(TICK_CYC), .QUIET_S(QUIET_S)) far_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .stop_cmd(stop_cmd), .panel_reset(panel_reset),
  .alarm_flags(alarm_flags), .alarm_relay(alarm_relay), .coast_req(coast_req),
  .stop_req(stop_req), .brake_req(brake_req), .restart_req(restart_req),
  .attempts_full(attempts_full));
`default_nettype wire

/* File: bench/far_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module far_stage_model (
  input  wire logic pclk,        // Clock
  input  wire logic presetn,     // Reset, low
  input  wire logic alarm_relay, // Relay
  input  wire logic slow,        // Long ramp
  output var  logic action_done  // Action over
);
  logic       relay_ff;
  logic [3:0] cnt_ff;
  // Done comes after a ramp, never in the cycle the alarm shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_ff    <= 1'b0;
      cnt_ff      <= 4'h0;
      action_done <= 1'b0;
    end else begin
      relay_ff    <= alarm_relay;
      action_done <= (cnt_ff == 4'h1);
      if (alarm_relay && !relay_ff)
        cnt_ff <= slow ? 4'h8 : 4'h2;
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/far_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "far_consts.vh"
module far_ctrl_bench;
  localparam int T = 10;
  logic        pclk, presetn, psel, penable, pwrite, cfg_panel, slow, rd_err;
  logic        mains_ok_pin, link_ok_pin, motor_run_pin, start_cmd, stop_cmd, panel_reset;
  logic        pready, pslverr, action_done, alarm_relay, coast_req, stop_req, brake_req;
  logic        restart_req, attempts_full;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [4:0]  fault_pin;
  logic [5:0]  act_on, alarm_flags;
  int          n_errors = 0, n_checks = 0, cyc = 0;

  far_ctrl #(.TICK_CYC(T), .QUIET_S(3)) far_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_panel(cfg_panel),
    .fault_pin(fault_pin), .mains_ok_pin(mains_ok_pin), .link_ok_pin(link_ok_pin),
    .motor_run_pin(motor_run_pin), .action_done(action_done), .act_on(act_on),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd), .panel_reset(panel_reset),
    .alarm_flags(alarm_flags), .alarm_relay(alarm_relay), .coast_req(coast_req),
    .stop_req(stop_req), .brake_req(brake_req), .restart_req(restart_req),
    .attempts_full(attempts_full));
  far_stage_model far_stage_model_inst (.pclk(pclk), .presetn(presetn),
    .alarm_relay(alarm_relay), .slow(slow), .action_done(action_done));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard, well above the longest run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the edge that samples pready high
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("rd_err", 32'h0, rd_err);
    chk("rd_data", exp, rd_data);
  endtask
  task automatic ctrl(input logic [3:0] att, input logic [1:0] src, input logic [2:0] act);
    apb(1'b1, `FAR_CTRL_OFS, {21'h0, act, 2'h0, src, att});
  endtask
  task automatic cmd(input logic [2:0] m);
    @(posedge pclk);
    {panel_reset, stop_cmd, start_cmd} <= m;
    @(posedge pclk);
    {panel_reset, stop_cmd, start_cmd} <= 3'h0;
  endtask
  task automatic wflag(input int i, input logic e);
    int n;
    n = 0;
    while (alarm_flags[i] !== e && n < 12) begin
      @(negedge pclk);
      n++;
    end
    chk("alarm_flag", {31'h0, e}, {31'h0, alarm_flags[i]});
  endtask
  task automatic wdone();
    int n;
    n = 0;
    while (action_done !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk("action_done", 32'h1, {31'h0, action_done});
  endtask
  task automatic quiet(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(negedge pclk);
      if (restart_req !== 1'b0) k++;
    end
    chk("no_restart", 32'h0, k);
  endtask
  task automatic wrst(input int lo, input int hi);
    int n;
    n = 0;
    while (restart_req !== 1'b1 && n <= hi) begin
      @(negedge pclk);
      n++;
    end
    chk("restart_time", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask

  task automatic t_regs();
    rd(`FAR_CTRL_OFS, 32'h310);
    rd(`FAR_SER_OFS, 32'h201);
    apb(1'b1, `FAR_DLY_OFS, 32'h5);
    rd(`FAR_DLY_OFS, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, rd_err);
    chk("unmapped_data", 32'h0, rd_data);
    apb(1'b1, `FAR_SER_OFS, 32'h14f7);
    rd(`FAR_SER_OFS, 32'h201);
    cfg_panel <= 1'b1;
    apb(1'b1, `FAR_SER_OFS, 32'h14f7);
    rd(`FAR_SER_OFS, 32'h14f7);
    apb(1'b1, `FAR_SER_OFS, 32'h0);
    rd(`FAR_SER_OFS, 32'hf7);
    ctrl(4'h0, `FAR_SRC_SERIAL, 3'h3);
    apb(1'b1, `FAR_SER_OFS, 32'h201);
    rd(`FAR_SER_OFS, 32'hf7);
    ctrl(4'h0, `FAR_SRC_REMOTE, 3'h3);
    apb(1'b1, `FAR_SER_OFS, 32'h201);
    rd(`FAR_SER_OFS, 32'h201);
    ctrl(4'h1, `FAR_SRC_PANEL, 3'h3);
    rd(`FAR_DLY_OFS, 32'h0);
    apb(1'b1, `FAR_DLY_OFS, 32'h2);
    rd(`FAR_DLY_OFS, 32'h2);
  endtask
  task automatic t_phase();
    fault_pin <= 5'h01;
    wflag(0, 1'b1);
    wdone();
    fault_pin <= 5'h00;
    quiet(4 * T);
    cmd(3'b100);
    wflag(0, 1'b0);
    quiet(T);
    act_on <= 6'h3f;
    fault_pin <= 5'h01;
    wdone();
    wrst(T, 3 * T);
    fault_pin <= 5'h00;
    repeat (2) @(negedge pclk);
    chk("full", 32'h1, {31'h0, attempts_full});
    cmd(3'b100);
    rd(`FAR_STAT_OFS, 32'h10000);
    repeat (4 * T) @(negedge pclk);
    chk("full", 32'h0, {31'h0, attempts_full});
  endtask
  task automatic t_clear(input int i);
    fault_pin <= 5'h01 << i;
    wdone();
    quiet(3 * T);
    fault_pin <= 5'h00;
    wrst(T, 3 * T + 5);
    chk("flag_clear", 32'h0, {31'h0, alarm_flags[i]});
  endtask
  task automatic t_mains();
    mains_ok_pin <= 1'b0;
    fault_pin <= 5'h04;
    wdone();
    wrst(T, 3 * T);
    repeat (2) @(negedge pclk);
    chk("flag_held", 32'h1, {31'h0, alarm_flags[2]});
    fault_pin <= 5'h00;
    mains_ok_pin <= 1'b1;
    wrst(T, 3 * T + 5);
    chk("flag_clear", 32'h0, {31'h0, alarm_flags[2]});
  endtask
  task automatic t_link();
    motor_run_pin <= 1'b1;
    for (int a = 1; a <= 4; a++) begin
      ctrl(4'h0, `FAR_SRC_SERIAL, a[2:0]);
      link_ok_pin <= 1'b0;
      wflag(5, 1'b1);
      repeat (2) @(negedge pclk);
      chk("relay", 32'h1, {31'h0, alarm_relay});
      chk("reqs", (a == 1) ? 0 : 1 << (a - 2), {brake_req, stop_req, coast_req});
      link_ok_pin <= 1'b1;
      if (a > 1) begin
        // Start only once the link is seen back, else the break re-sets the flag
        repeat (3) @(negedge pclk);
        cmd(3'b001);
      end
      wflag(5, 1'b0);
    end
    ctrl(4'h0, `FAR_SRC_SERIAL, `FAR_ACT_OFF);
    link_ok_pin <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("off_flag", 32'h0, {31'h0, alarm_flags[5]});
    ctrl(4'h0, `FAR_SRC_PANEL, `FAR_ACT_STOP);
    repeat (8) @(negedge pclk);
    chk("panel_flag", 32'h0, {31'h0, alarm_flags[5]});
    link_ok_pin <= 1'b1;
  endtask

  initial begin
    {psel, penable, pwrite, cfg_panel, slow, start_cmd, stop_cmd, panel_reset} = 8'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_pin = 5'h00;
    act_on = 6'h00;
    {mains_ok_pin, link_ok_pin, motor_run_pin} = 3'b110;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_phase();
    ctrl(4'ha, `FAR_SRC_PANEL, `FAR_ACT_STOP);
    for (int i = 1; i <= 4; i++) apb(1'b1, 8'(`FAR_DLY_OFS + 4 * i), 32'h2);
    slow <= 1'b1;
    for (int i = 1; i <= 4; i++) t_clear(i);
    rd(`FAR_STAT_OFS, 32'h40000);
    cmd(3'b010);
    rd(`FAR_STAT_OFS, 32'h0);
    t_mains();
    t_link();
    end_sim();
  end
endmodule
`default_nettype wire
